// [sspr_consts.svh]
// register indices, field positions, reset values and counts of the serial port
// assumes the byte address of a register is four times its index
`ifndef SSPR_CONSTS_SVH
`define SSPR_CONSTS_SVH

// ----------------------------------------------------------------
// register indices (byte address = index * 4)
// ----------------------------------------------------------------
`define SSPR_IDX_STATUS     16'h4320
`define SSPR_IDX_TX_BYTE    16'h4322
`define SSPR_IDX_RX_BYTE    16'h4324
`define SSPR_IDX_CONTROL    16'h4326
`define SSPR_IDX_EVT_STATUS 16'h4328
`define SSPR_IDX_EVT_ENABLE 16'h432a
`define SSPR_IDX_EVT_CLEAR  16'h432c

// ----------------------------------------------------------------
// status fields
// ----------------------------------------------------------------
`define SSPR_ST_TX_EMPTY 0
`define SSPR_ST_RX_FULL  1
`define SSPR_ST_BUSY     2

// ----------------------------------------------------------------
// control fields
// ----------------------------------------------------------------
`define SSPR_CTL_ENABLE  0
`define SSPR_CTL_MASTER  1
`define SSPR_CTL_CLOCK_POLARITY_SELECT    2
`define SSPR_CTL_CPHA    3
`define SSPR_CTL_TX_IE   4
`define SSPR_CTL_RX_IE   5
`define SSPR_CTL_WIDTH   6
`define SSPR_CTL_RESET   6'h00

// ----------------------------------------------------------------
// event bits: 0 byte received, 1 transmit byte taken
// ----------------------------------------------------------------
`define SSPR_EVT_RX      0
`define SSPR_EVT_TX      1
`define SSPR_EVT_WIDTH   2

// ----------------------------------------------------------------
// reset values and counts
// ----------------------------------------------------------------
`define SSPR_BYTE_RESET  8'h00
`define SSPR_HALF_PERIODS 16
`define SSPR_SCLK_HALF   8

`endif

// [sspr_pkg.sv]
// types shared by the serial port register block
// numbers written out here; sspr_consts.svh is not included
`default_nettype none
package sspr_pkg;

    // master sequencer, gray coded
    typedef enum logic [1:0] {
        SSPR_ST_IDLE  = 2'b00,
        SSPR_ST_SHIFT = 2'b01
    } sspr_state_t;

    typedef logic [7:0] sspr_byte_t;

endpackage : sspr_pkg

`default_nettype wire

// [sspr_regs.sv]
// 8-bit serial peripheral port, master or slave, with an apb register slave
// assumes apb on ref_clk; serial pins come from outside and are synchronised
//
// How it works
// RULE_01: master mode, status bit 2 reads 1 while a transfer runs, else 0.
// RULE_02: slave mode, status bit 2 reads 1 while slave select is low.
// RULE_03: status bit 1 is 1 while the receive byte buffer is full.
// RULE_04: status bit 0 is 1 while the transmit byte buffer is empty.
// RULE_05: transmit register holds an 8-bit read/write byte, msb first, reset zero.
// RULE_06: receive register shows each received byte, read-only, reset zero.
// RULE_07: control bit 5 requests an interrupt while the receive buffer is full.
// RULE_08: control bit 4 requests an interrupt while the transmit buffer is empty.
// RULE_09: control bits: 3 phase, 2 polarity, 1 master, 0 enable; reset zero.
// RULE_10: software sets phase, polarity and mode before enabling, never while enabled.
`timescale 1ns/10ps
`default_nettype none
`include "sspr_consts.svh"

module sspr_regs #(
    parameter int ADDR_W    = 20,
    parameter int SCLK_HALF = `SSPR_SCLK_HALF
) (
    // clock and reset
    input  wire logic              ref_clk,
    input  wire logic              rst_n,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output var  logic [31:0]       prdata,
    output var  logic              pready,
    output var  logic              pslverr,
    // serial link
    input  wire logic              sclk_in,
    output var  logic              sclk_out,
    output var  logic              sclk_oe_n,
    input  wire logic              ss_n_in,
    input  wire logic              sdi,
    output var  logic              sdo,
    output var  logic              sdo_oe_n,
    // interrupt
    output var  logic              irq
);
    import sspr_pkg::*;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic                      pready_q, pslverr_q;
    logic [31:0]               prdata_q;
    sspr_byte_t                tx_byte_q, rx_byte_q, tsh_q, rsh_q;
    logic                      tx_empty_q, rx_full_q;
    logic [`SSPR_CTL_WIDTH-1:0] ctl_q;
    logic [`SSPR_EVT_WIDTH-1:0] evt_q, evt_en_q;
    sspr_state_t               st_q;
    logic [15:0]               div_q;
    logic [3:0]                half_q;
    logic [2:0]                bit_q;
    logic                      sclk_q, sdo_q, sclk_oe_n_q, sdo_oe_n_q, irq_q;
    logic                      sclk_s1, sclk_s2, sclk_s3;
    logic                      ss_s1, ss_s2, ss_s3;
    logic                      sdi_s1, sdi_s2;

    // ----------------------------------------------------------------
    // apb decode
    // ----------------------------------------------------------------
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [15:0] idx);
        hit = (a[ADDR_W-1:2] == (ADDR_W-2)'(idx)) && (a[1:0] == 2'b00);
    endfunction : hit

    wire        acc       = psel && penable && !pready_q;
    wire        done      = psel && penable && pready_q;
    wire        wr        = done && pwrite && !pslverr_q;
    wire        rd        = done && !pwrite && !pslverr_q;
    wire        a_status  = hit(paddr, `SSPR_IDX_STATUS);
    wire        a_tx      = hit(paddr, `SSPR_IDX_TX_BYTE);
    wire        a_rx      = hit(paddr, `SSPR_IDX_RX_BYTE);
    wire        a_ctl     = hit(paddr, `SSPR_IDX_CONTROL);
    wire        a_evt     = hit(paddr, `SSPR_IDX_EVT_STATUS);
    wire        a_evt_en  = hit(paddr, `SSPR_IDX_EVT_ENABLE);
    wire        a_evt_clr = hit(paddr, `SSPR_IDX_EVT_CLEAR);
    wire        mapped    = a_status | a_tx | a_rx | a_ctl | a_evt | a_evt_en | a_evt_clr;

    // ----------------------------------------------------------------
    // control fields
    // ----------------------------------------------------------------
    wire en     = ctl_q[`SSPR_CTL_ENABLE];
    wire master = ctl_q[`SSPR_CTL_MASTER];
    wire clock_polarity_select   = ctl_q[`SSPR_CTL_CLOCK_POLARITY_SELECT];
    wire cpha   = ctl_q[`SSPR_CTL_CPHA];

    // ----------------------------------------------------------------
    // serial edges, master generated or slave observed
    // ----------------------------------------------------------------
    wire m_tick   = (st_q == SSPR_ST_SHIFT) && (div_q == 16'(SCLK_HALF - 1));
    wire m_start  = en && master && (st_q == SSPR_ST_IDLE) && !tx_empty_q;
    wire m_last   = m_tick && (half_q == 4'(`SSPR_HALF_PERIODS - 1));
    wire selected = en && !master && !ss_s2;
    wire s_rise   = sclk_s2 && !sclk_s3;
    wire s_fall   = !sclk_s2 && sclk_s3;
    wire s_lead   = selected && (clock_polarity_select ? s_fall : s_rise);
    wire s_trail  = selected && (clock_polarity_select ? s_rise : s_fall);
    wire ss_fall  = en && !master && !ss_s2 && ss_s3;
    // leading edge is the one leaving the idle level
    wire lead_ev  = master ? (m_tick && !half_q[0]) : s_lead;
    wire trail_ev = master ? (m_tick && half_q[0]) : s_trail;
    // phase picks which edge samples and which shifts
    wire sample_ev = cpha ? trail_ev : lead_ev; // RULE_09
    wire shift_ev  = cpha ? lead_ev : trail_ev; // RULE_09
    wire byte_done = sample_ev && (bit_q == 3'h7);
    wire s_load    = ss_fall || (selected && byte_done);
    wire load      = m_start || s_load;
    wire tx_taken  = load && !tx_empty_q;
    wire sspr_byte_t rx_next = {rsh_q[6:0], sdi_s2};
    wire busy_bit  = master ? (st_q == SSPR_ST_SHIFT) : !ss_s2;

    // ----------------------------------------------------------------
    // read mux
    // ----------------------------------------------------------------
    wire [31:0] rd_status = {29'h0, busy_bit, rx_full_q, tx_empty_q}; // RULE_01 RULE_02 RULE_03 RULE_04
    wire [31:0] rd_mux =
        a_status ? rd_status :
        a_tx     ? {24'h0, tx_byte_q} : // RULE_05
        a_rx     ? {24'h0, rx_byte_q} : // RULE_06
        a_ctl    ? {26'h0, ctl_q} :
        a_evt    ? {30'h0, evt_q} :
        a_evt_en ? {30'h0, evt_en_q} : 32'h0;

    wire irq_d = (ctl_q[`SSPR_CTL_RX_IE] && rx_full_q)  // RULE_07
              || (ctl_q[`SSPR_CTL_TX_IE] && tx_empty_q) // RULE_08
              || |(evt_q & evt_en_q);

    // ----------------------------------------------------------------
    // apb answer: one wait state, registered data
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0;
        end else begin
            pready_q  <= acc;
            pslverr_q <= acc && !mapped;
            prdata_q  <= (acc && !pwrite && mapped) ? rd_mux : 32'h0;
        end
    end

    // ----------------------------------------------------------------
    // software registers
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ctl_q     <= `SSPR_CTL_RESET; // RULE_09
            tx_byte_q <= `SSPR_BYTE_RESET; // RULE_05
            evt_en_q  <= '0;
        end else begin
            if (wr && a_ctl)
                ctl_q <= pwdata[`SSPR_CTL_WIDTH-1:0]; // RULE_09
            if (wr && a_tx)
                tx_byte_q <= pwdata[7:0]; // RULE_05
            if (wr && a_evt_en)
                evt_en_q <= pwdata[`SSPR_EVT_WIDTH-1:0];
        end
    end

    // ----------------------------------------------------------------
    // buffer flags and events; a set beats a clear in the same cycle, except tx_empty_q, where a transmit write beats a load
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            tx_empty_q <= 1'b1; // RULE_04
            rx_full_q  <= 1'b0; // RULE_03
            rx_byte_q  <= `SSPR_BYTE_RESET; // RULE_06
            evt_q      <= '0;
            irq_q      <= 1'b0;
        end else begin
            // a fresh write survives a load of the previous byte
            if (wr && a_tx)
                tx_empty_q <= 1'b0; // RULE_04
            else if (load)
                tx_empty_q <= 1'b1; // RULE_04
            if (byte_done) begin
                rx_full_q <= 1'b1; // RULE_03
                rx_byte_q <= rx_next; // RULE_06
            end else if (rd && a_rx) begin
                rx_full_q <= 1'b0; // RULE_03
            end
            evt_q[`SSPR_EVT_RX] <= byte_done
                || (evt_q[`SSPR_EVT_RX] && !(wr && a_evt_clr && pwdata[`SSPR_EVT_RX]));
            evt_q[`SSPR_EVT_TX] <= tx_taken
                || (evt_q[`SSPR_EVT_TX] && !(wr && a_evt_clr && pwdata[`SSPR_EVT_TX]));
            irq_q <= irq_d;
        end
    end

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            // select reset as low so the slave flag starts at 1
            {sclk_s1, sclk_s2, sclk_s3} <= 3'h0;
            {ss_s1, ss_s2, ss_s3}       <= 3'h0; // RULE_02
            {sdi_s1, sdi_s2}            <= 2'h0;
        end else begin
            sclk_s1 <= sclk_in;
            sclk_s2 <= sclk_s1;
            sclk_s3 <= sclk_s2;
            ss_s1   <= ss_n_in;
            ss_s2   <= ss_s1;
            ss_s3   <= ss_s2;
            sdi_s1  <= sdi;
            sdi_s2  <= sdi_s1;
        end
    end

    // ----------------------------------------------------------------
    // master sequencer and clock divider
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            st_q   <= SSPR_ST_IDLE;
            div_q  <= 16'h0;
            half_q <= 4'h0;
            sclk_q <= 1'b0;
        end else begin
            case (st_q)
                SSPR_ST_IDLE: begin
                    div_q  <= 16'h0;
                    half_q <= 4'h0;
                    sclk_q <= clock_polarity_select; // RULE_09
                    if (m_start)
                        st_q <= SSPR_ST_SHIFT; // RULE_01
                end
                SSPR_ST_SHIFT: begin
                    div_q <= m_tick ? 16'h0 : div_q + 16'h1;
                    if (m_tick) begin
                        sclk_q <= !sclk_q;
                        half_q <= half_q + 4'h1;
                    end
                    // dropping enable aborts the byte
                    if (m_last || !en)
                        st_q <= SSPR_ST_IDLE; // RULE_01
                end
                default: st_q <= SSPR_ST_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // shifters, common to both modes; mode bits are assumed stable
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            tsh_q <= `SSPR_BYTE_RESET;
            rsh_q <= `SSPR_BYTE_RESET;
            bit_q <= 3'h0;
            sdo_q <= 1'b0;
        end else begin
            if (load) begin
                tsh_q <= tx_byte_q; // RULE_10
                bit_q <= 3'h0;
                if (!cpha)
                    sdo_q <= tx_byte_q[7];
            end else begin
                if (shift_ev) begin
                    sdo_q <= cpha ? tsh_q[7] : tsh_q[6];
                    tsh_q <= {tsh_q[6:0], 1'b0};
                end
                if (sample_ev) begin
                    rsh_q <= rx_next;
                    bit_q <= bit_q + 3'h1;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // pin drivers and outputs
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            sclk_oe_n_q <= 1'b1;
            sdo_oe_n_q  <= 1'b1;
        end else begin
            sclk_oe_n_q <= !(en && master);
            // slave releases its output while not selected
            sdo_oe_n_q  <= !(en && (master || !ss_s2));
        end
    end

    assign prdata    = prdata_q;
    assign pready    = pready_q;
    assign pslverr   = pslverr_q;
    assign sclk_out  = sclk_q;
    assign sclk_oe_n = sclk_oe_n_q;
    assign sdo       = sdo_q;
    assign sdo_oe_n  = sdo_oe_n_q;
    assign irq       = irq_q;

endmodule : sspr_regs

`default_nettype wire

// [sspr_chk_sva.sv]
// checker on the ports of the serial port register block
// assumes bind into sspr_regs; control and event enable shadowed from apb writes
`timescale 1ns/10ps
`default_nettype none
module sspr_chk #(
    parameter int ADDR_W = 20
) (
    // clock and reset
    input wire logic              ref_clk,
    input wire logic              rst_n,
    // apb
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    // pins
    input wire logic              sclk_oe_n,
    input wire logic              sdo_oe_n,
    input wire logic              irq
);
    localparam logic [ADDR_W-1:0] A_ST = ADDR_W'(20'h10c80);
    localparam logic [ADDR_W-1:0] A_TX = ADDR_W'(20'h10c88);
    localparam logic [ADDR_W-1:0] A_RX = ADDR_W'(20'h10c90);
    localparam logic [ADDR_W-1:0] A_CT = ADDR_W'(20'h10c98);
    localparam logic [ADDR_W-1:0] A_IE = ADDR_W'(20'h10ca8);
    logic [5:0] ctl_q;
    logic [1:0] ien_q;
    wire        done_w = psel && penable && pready;
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ctl_q <= 6'h00;
            ien_q <= 2'h0;
        end else if (done_w && pwrite && paddr == A_CT) begin
            ctl_q <= pwdata[5:0];
        end else if (done_w && pwrite && paddr == A_IE) begin
            ien_q <= pwdata[1:0];
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    sequence s_rd(a);
        done_w && !pwrite && paddr == a;
    endsequence
    // two samples needed: pin enables are registered behind the control bit
    sequence s_off;
        !ctl_q[0] [*2];
    endsequence
    a_ctl_readback: assert property (s_rd(A_CT) |-> prdata == {26'h0, ctl_q})
        else $error("control reads back wrong");
    a_tx_upper: assert property (s_rd(A_TX) |-> prdata[31:8] == 24'h0)
        else $error("transmit upper bits not zero");
    a_rx_upper: assert property (s_rd(A_RX) |-> prdata[31:8] == 24'h0)
        else $error("receive upper bits not zero");
    a_status_upper: assert property (s_rd(A_ST) |-> prdata[31:3] == 29'h0)
        else $error("status upper bits not zero");
    a_oe_needs_master: assert property ($fell(sclk_oe_n) |-> ctl_q[1:0] == 2'b11)
        else $error("clock driven without master enable");
    a_sclk_released: assert property (s_off |-> sclk_oe_n)
        else $error("clock driven while disabled");
    a_sdo_released: assert property (s_off |-> sdo_oe_n)
        else $error("data driven while disabled");
    a_irq_quiet: assert property ((ctl_q[5:4] == 2'b00 && ien_q == 2'b00) [*2] |-> !irq)
        else $error("interrupt without enable");
endmodule : sspr_chk
bind sspr_regs sspr_chk #(.ADDR_W(ADDR_W)) i_sspr_chk (
    .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .sclk_oe_n(sclk_oe_n), .sdo_oe_n(sdo_oe_n), .irq(irq)
);
`default_nettype wire

// [sspr_far_end.sv]
// far-end serial slave answering the port in master mode
// assumes sclk from the port; edges found by sampling on ref_clk
`timescale 1ns/10ps
`default_nettype none
module sspr_far_end (
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    // mode and answer byte
    input  wire logic       clock_polarity_select,
    input  wire logic       cpha,
    input  wire logic [7:0] reply,
    // serial pins
    input  wire logic       sclk,
    input  wire logic       sclk_oe_n,
    input  wire logic       mosi,
    output logic            miso,
    output logic [7:0]      got
);
    logic       sclk_q;
    logic [7:0] sh_q;
    logic [2:0] n_q;
    logic       ob_q;
    wire        lead = sclk != sclk_q && sclk != clock_polarity_select;
    wire        trail = sclk != sclk_q && sclk == clock_polarity_select;
    wire        smp = cpha ? trail : lead;
    wire        chg = cpha ? lead : trail;
    // released line shows the inverse, never a stale copy
    assign miso = sclk_oe_n ? ~sh_q[7] : (cpha ? ob_q : sh_q[7]);
    always_ff @(posedge ref_clk) begin
        sclk_q <= sclk;
        if (!rst_n || sclk_oe_n) begin
            sh_q <= reply;
            n_q <= 3'h0;
        end else if (chg) begin
            ob_q <= sh_q[7];
            sh_q <= (n_q == 3'h7) ? reply : {sh_q[6:0], 1'b0};
            n_q <= n_q + 3'h1;
        end
        if (smp && !sclk_oe_n) begin
            got <= {got[6:0], mosi};
        end
    end
endmodule : sspr_far_end
`default_nettype wire

// [serial_peripheral_port_regs_bench.sv]
// bench of the serial port register block: apb tasks and a far-end slave
// assumes sspr_regs and sspr_far_end; slave-mode link clock made here
`timescale 1ns/10ps
`default_nettype none
module serial_peripheral_port_regs_bench;
    import sspr_pkg::*;
    localparam logic [19:0] A_ST = 20'h10c80, A_TX = 20'h10c88, A_RX = 20'h10c90;
    localparam logic [19:0] A_CT = 20'h10c98, A_ES = 20'h10ca0, A_EE = 20'h10ca8;
    localparam logic [19:0] A_EC = 20'h10cb0, A_NO = 20'h10cb8;
    localparam sspr_byte_t  MO = 8'hc3;
    logic        ref_clk, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [19:0] paddr = 20'h0;
    logic [31:0] pwdata = 32'h0;
    logic        sclk_in = 1'b0, ss_n_in = 1'b0, mosi_q = 1'b0, slv = 1'b0;
    logic        clock_polarity_select = 1'b0, cpha = 1'b0;
    sspr_byte_t  reply = 8'ha5, cap;
    wire  [31:0] prdata;
    wire         pready, pslverr, sclk_out, sclk_oe_n, sdo, sdo_oe_n, irq, miso;
    wire  [7:0]  got;
    wire         sdi = slv ? mosi_q : miso;
    int          err_total = 0, checks_done = 0, cyc = 0;
    sspr_regs #(.ADDR_W(20), .SCLK_HALF(8)) i_sspr_regs (
        .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sclk_in(sclk_in), .sclk_out(sclk_out),
        .sclk_oe_n(sclk_oe_n), .ss_n_in(ss_n_in), .sdi(sdi), .sdo(sdo),
        .sdo_oe_n(sdo_oe_n), .irq(irq));
    sspr_far_end i_sspr_far_end (
        .ref_clk(ref_clk), .rst_n(rst_n), .clock_polarity_select(clock_polarity_select), .cpha(cpha), .reply(reply),
        .sclk(sclk_out), .sclk_oe_n(sclk_oe_n), .mosi(sdo), .miso(miso), .got(got));
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic conclude;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : conclude
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            conclude();
        end
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    // one setup cycle, then access held until pready is seen at an edge
    task automatic apb(input logic w, input logic [19:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [19:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, q, e);
    endtask : wr
    task automatic rdc(input logic [19:0] a, input logic [31:0] x);
        logic [31:0] q;
        logic        e;
        apb(1'b0, a, 32'h0, q, e);
        chk(q, x);
    endtask : rdc
    task automatic wait_st(input logic [31:0] x);
        logic [31:0] q;
        logic        e;
        int          n;
        n = 0;
        do begin
            apb(1'b0, A_ST, 32'h0, q, e);
            n++;
        end while (q !== x && n < 200);
        chk(q, x);
    endtask : wait_st
    task automatic chk_irq(input logic x);
        repeat (3) @(posedge ref_clk);
        chk(32'(irq), 32'(x));
    endtask : chk_irq
    // ----------------------------------------------------------------
    // test sequence
    // ----------------------------------------------------------------
    initial begin : main
        logic [31:0] q;
        logic        e;
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        rdc(A_ST, 32'h5);
        rdc(A_TX, 32'h0);
        rdc(A_RX, 32'h0);
        rdc(A_CT, 32'h0);
        ss_n_in <= 1'b1;
        rdc(A_ST, 32'h1);
        wr(A_ST, 32'hffff);
        wr(A_RX, 32'hffff);
        rdc(A_ST, 32'h1);
        rdc(A_RX, 32'h0);
        wr(A_TX, 32'hffff);
        rdc(A_TX, 32'hff);
        rdc(A_ST, 32'h0);
        wr(A_CT, 32'hfff0);
        rdc(A_CT, 32'h30);
        wr(A_CT, 32'h0);
        apb(1'b0, A_NO, 32'h0, q, e);
        chk({q[31:1], e}, 32'h1);
        $display("test registers done");
        // slave byte in both polarities, clock made here at 160 ns
        slv <= 1'b1;
        for (int p = 0; p < 2; p++) begin
            sclk_in <= p[0];
            wr(A_CT, 32'(p * 4));
            wr(A_CT, 32'(p * 4 + 1));
            wr(A_TX, 32'h3c);
            ss_n_in <= 1'b0;
            for (int i = 7; i >= 0; i--) begin
                mosi_q <= MO[i];
                repeat (8) @(posedge ref_clk);
                sclk_in <= ~p[0];
                cap[i] = sdo;
                repeat (8) @(posedge ref_clk);
                sclk_in <= p[0];
            end
            repeat (8) @(posedge ref_clk);
            ss_n_in <= 1'b1;
            rdc(A_ST, 32'h3);
            rdc(A_RX, 32'(MO));
            chk(32'(cap), 32'h3c);
            rdc(A_ST, 32'h1);
            wr(A_CT, 32'h0);
        end
        slv <= 1'b0;
        $display("test slave done");
        for (int m = 0; m < 4; m++) begin
            clock_polarity_select <= m[0];
            cpha <= m[1];
            reply <= 8'ha5 ^ 8'(m);
            wr(A_CT, 32'(m * 4 + 2));
            wr(A_CT, 32'(m * 4 + 3));
            chk(32'(sclk_out), 32'(m[0]));
            wr(A_TX, 32'h3c);
            rdc(A_ST, 32'h5);
            wr(A_TX, 32'(8'h69 + 8'(m)));
            rdc(A_ST, 32'h4);
            wait_st(32'h3);
            rdc(A_RX, 32'(reply));
            chk(32'(got), 32'(8'h69 + 8'(m)));
            rdc(A_ST, 32'h1);
            wr(A_CT, 32'h0);
        end
        $display("test master done");
        clock_polarity_select <= 1'b0;
        cpha <= 1'b0;
        wr(A_EC, 32'h3);
        rdc(A_ES, 32'h0);
        wr(A_CT, 32'h10);
        chk_irq(1'b1);
        wr(A_CT, 32'h0);
        chk_irq(1'b0);
        wr(A_CT, 32'h22);
        wr(A_CT, 32'h23);
        wr(A_TX, 32'h11);
        wait_st(32'h3);
        chk_irq(1'b1);
        rdc(A_RX, 32'(reply));
        chk_irq(1'b0);
        rdc(A_ES, 32'h3);
        wr(A_EE, 32'h1);
        chk_irq(1'b1);
        wr(A_EC, 32'h1);
        chk_irq(1'b0);
        rdc(A_ES, 32'h2);
        wr(A_EE, 32'h0);
        $display("test interrupts done");
        conclude();
    end
endmodule : serial_peripheral_port_regs_bench
`default_nettype wire
